// ### hw/sacr_defines.vh
/*
 Constants for the sensor short-address and configuration-2 register block.
 Assumes inclusion by bare name from the design file.
*/
`ifndef SACR_DEFINES_VH
`define SACR_DEFINES_VH

`define SACR_OFS_CFG2          8'h05
`define SACR_OFS_NODE_ID       8'h06
`define SACR_CFG2_RESET        8'h80
`define SACR_NODE_ID_RESET     8'h00

`define SACR_BIT_OVERDRIVE     7
`define SACR_BIT_LOCK          0
`define SACR_SRC_HI            6
`define SACR_SRC_LO            5
`define SACR_ARB_HI            4
`define SACR_ARB_LO            3
`define SACR_HYST_HI           2
`define SACR_HYST_LO           1

`define SACR_SRC_HOST          2'h0
`define SACR_SRC_IO            2'h1
`define SACR_SRC_RES           2'h2
`define SACR_SRC_BOTH          2'h3

`define SACR_ARB_OFF           2'h0
`define SACR_ARB_RSVD          2'h1
`define SACR_ARB_SW            2'h2
`define SACR_ARB_FAST          2'h3

`define SACR_STAGGER_STEP_NS   1000
`define SACR_CLK_PERIOD_NS     10
`define SACR_STAGGER_STEP_CYC  (`SACR_STAGGER_STEP_NS / `SACR_CLK_PERIOD_NS)

`endif

// ### hw/sacr_regs.v
/*
 Configuration-2 and short node address registers of a single-wire
 temperature sensor, with address source decode and conversion stagger.
 Assumes the bus protocol engine presents decoded scratchpad writes,
 commit strobes and reset events, all synchronous to i_clk.
*/
// Contract
// [RULE_01] Config bit 7 reports overdrive; 1 enabled, host writes never clear it.
// [RULE_02] Overdrive bit cleared only by a standard-speed reset pulse.
// [RULE_03] Bits 6:5 select address source: host, IO, resistor, or both.
// [RULE_04] New address source applied only when the field value changes.
// [RULE_05] Bits 4:3 select arbitration: off, reserved, software, fast.
// [RULE_06] Arbitration setting applies only during the address discovery command.
// [RULE_07] Bits 2:1 select alert hysteresis of 5, 10, 15, 20 degrees.
// [RULE_08] Lock bit 0 resets to zero and once set cannot be cleared.
// [RULE_09] Lock blocks writes to offset, alert limits, short address, configuration.
// [RULE_10] Short address register at offset 06h, 8 bits, reset 00h.
// [RULE_11] Commit stores short address to storage; power-on reloads it.
// [RULE_12] Decoded strap bits overlay restored value; other bits keep it.
// [RULE_13] Host writes to short address ignored unless source is 00b.
// [RULE_14] Source 0 uses the full register value unchanged.
// [RULE_15] Source 1 or 2: upper nibble stored, lower from IO or resistor.
// [RULE_16] Source 3: top two stored, next two strap lines 1:0, low four resistor.
// [RULE_17] Stacked conversion mode delays conversion start by short address.
// [RULE_18] Host writes all bytes and reads CRC before overdrive or lock apply.
// [RULE_19] Host keeps bus idle for resistor detect time after decode select.
// [RULE_20] Configuration-2 register at offset 05h, reset 80h.
// [RULE_21] Resistor to four-bit code decode is an external input.
`timescale 1ns/10ps
`default_nettype none
`include "sacr_defines.vh"

module sacr_regs
(
	input  wire        i_clk,
	input  wire        i_reset_n,
	input  wire        i_por_load,
	input  wire [7:0]  i_nv_cfg2,
	input  wire [7:0]  i_nv_node_id,
	input  wire        i_wr_en,
	input  wire [7:0]  i_wr_addr,
	input  wire [7:0]  i_wr_data,
	input  wire        i_frame_done,
	input  wire        i_std_reset_pulse,
	input  wire        i_commit,
	input  wire [3:0]  i_strap_lines,
	input  wire [3:0]  i_resistor_code,
	input  wire        i_discovery_active,
	input  wire        i_stacked_mode,
	input  wire        i_conv_request,
	input  wire [7:0]  i_rd_addr,
	output reg  [7:0]  o_rd_data,
	output reg  [7:0]  o_cfg2,
	output reg  [7:0]  o_node_id,
	output reg         o_nv_store,
	output reg  [7:0]  o_nv_cfg2,
	output reg  [7:0]  o_nv_node_id,
	output wire        o_lock_active,
	output wire [1:0]  o_arbitration_select,
	output wire [4:0]  o_hyst_deg_c,
	output wire        o_overdrive,
	output reg         o_conv_start,
	output wire        o_conv_busy
);

	reg  [7:0]  cfg2_ff;
	reg  [7:0]  nxt_cfg2;
	reg  [7:0]  node_ff;
	reg  [7:0]  nxt_node;
	reg  [7:0]  nv_node_ff;
	reg  [1:0]  src_prev_ff;
	reg         pend_od_ff;
	reg         nxt_pend_od;
	reg         pend_lock_ff;
	reg         nxt_pend_lock;
	reg  [15:0] stag_cnt_ff;
	reg  [15:0] nxt_stag_cnt;
	reg         stag_busy_ff;
	reg         nxt_stag_busy;
	reg         nxt_conv_start;

	// Scratchpad offset match, shared by write decode and read mux
	function sacr_hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			sacr_hit = (addr == ofs);
		end
	endfunction

	wire [1:0]  src_sel   = cfg2_ff[`SACR_SRC_HI:`SACR_SRC_LO];
	wire        locked    = cfg2_ff[`SACR_BIT_LOCK];
	wire        wr_cfg    = i_wr_en & sacr_hit(i_wr_addr, `SACR_OFS_CFG2);
	wire        wr_node   = i_wr_en & sacr_hit(i_wr_addr, `SACR_OFS_NODE_ID);
	wire        cfg_open  = wr_cfg & ~locked;
	// Largest address times the step stays below 2^16, so the cut is safe
	wire [31:0] stag_prod = node_ff * `SACR_STAGGER_STEP_CYC;
	wire [15:0] stag_load = stag_prod[15:0];

	// Build the node address from a stored value and the strap inputs
	function [7:0] sacr_overlay;
		input [1:0] src;
		input [7:0] stored;
		input [3:0] io;
		input [3:0] res;
		begin
			case (src)
				`SACR_SRC_IO:   sacr_overlay = {stored[7:4], io};        // [RULE_15]
				`SACR_SRC_RES:  sacr_overlay = {stored[7:4], res};       // [RULE_15] [RULE_21]
				`SACR_SRC_BOTH: sacr_overlay = {stored[7:6], io[1:0], res}; // [RULE_16]
				default:        sacr_overlay = stored;                   // [RULE_14]
			endcase
		end
	endfunction

	// Hysteresis in degrees: five per code step, starting at five
	function [4:0] sacr_hyst_deg;
		input [1:0] code;
		begin
			sacr_hyst_deg = {1'b0, code, 2'b00} + {3'b000, code} + 5'd5;
		end
	endfunction

	// Configuration-2 next value
	always @*
	begin
		nxt_cfg2 = cfg2_ff;
		if (cfg_open)                                                    // [RULE_09]
		begin
			nxt_cfg2[6:1] = i_wr_data[6:1];                              // [RULE_03] [RULE_05] [RULE_07]
		end
		// Overdrive and lock only take hold once the frame closes with CRC read
		if (i_frame_done && pend_od_ff)                                  // [RULE_18]
		begin
			nxt_cfg2[`SACR_BIT_OVERDRIVE] = 1'b1;
		end
		if (i_frame_done && pend_lock_ff)
		begin
			nxt_cfg2[`SACR_BIT_LOCK] = 1'b1;                             // [RULE_08]
		end
		if (i_std_reset_pulse)
		begin
			nxt_cfg2[`SACR_BIT_OVERDRIVE] = 1'b0;                        // [RULE_02]
		end
	end

	// Pending marks: set by a write, consumed when the frame closes
	always @*
	begin
		nxt_pend_od   = pend_od_ff;
		nxt_pend_lock = pend_lock_ff;
		if (i_frame_done)
		begin
			nxt_pend_od   = 1'b0;
			nxt_pend_lock = 1'b0;
		end
		else if (cfg_open)
		begin
			nxt_pend_od   = i_wr_data[`SACR_BIT_OVERDRIVE];              // [RULE_01]
			nxt_pend_lock = i_wr_data[`SACR_BIT_LOCK];                   // [RULE_08]
		end
	end

	// Short address next value
	always @*
	begin
		nxt_node = node_ff;
		if (src_sel != src_prev_ff)                                      // [RULE_04]
		begin
			nxt_node = sacr_overlay(src_sel, nv_node_ff, i_strap_lines, i_resistor_code); // [RULE_12]
		end
		else if (wr_node && !locked && src_sel == `SACR_SRC_HOST)        // [RULE_13] [RULE_09]
		begin
			nxt_node = i_wr_data;
		end
	end

	// Stagger counter: short address times a fixed step
	always @*
	begin
		nxt_stag_cnt   = stag_cnt_ff;
		nxt_stag_busy  = stag_busy_ff;
		nxt_conv_start = 1'b0;
		if (i_conv_request && !stag_busy_ff)
		begin
			if (i_stacked_mode && node_ff != 8'h00)                      // [RULE_17]
			begin
				nxt_stag_cnt  = stag_load;
				nxt_stag_busy = 1'b1;
			end
			else
			begin
				nxt_conv_start = 1'b1;
			end
		end
		else if (stag_busy_ff)
		begin
			if (stag_cnt_ff == 16'h0001)
			begin
				nxt_stag_busy  = 1'b0;
				nxt_conv_start = 1'b1;
			end
			nxt_stag_cnt = stag_cnt_ff - 16'h0001;
		end
	end

	// Register state; a storage reload outranks any write in the same cycle
	always @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			cfg2_ff      <= `SACR_CFG2_RESET;                            // [RULE_20]
			node_ff      <= `SACR_NODE_ID_RESET;                         // [RULE_10]
			src_prev_ff  <= `SACR_SRC_HOST;
			pend_od_ff   <= 1'b0;
			pend_lock_ff <= 1'b0;
		end
		else if (i_por_load)
		begin
			// Source field is not kept in storage; it restarts at host mode
			cfg2_ff      <= {i_nv_cfg2[7], 2'b00, i_nv_cfg2[4:0]};       // [RULE_11]
			node_ff      <= i_nv_node_id;                                // [RULE_11]
			src_prev_ff  <= `SACR_SRC_HOST;
			pend_od_ff   <= 1'b0;
			pend_lock_ff <= 1'b0;
		end
		else
		begin
			cfg2_ff      <= nxt_cfg2;
			node_ff      <= nxt_node;
			src_prev_ff  <= src_sel;
			pend_od_ff   <= nxt_pend_od;
			pend_lock_ff <= nxt_pend_lock;
		end
	end

	// Storage image: restored copy and commit outputs
	always @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			nv_node_ff   <= `SACR_NODE_ID_RESET;
			o_nv_store   <= 1'b0;
			o_nv_cfg2    <= 8'h00;
			o_nv_node_id <= 8'h00;
		end
		else if (i_por_load)
		begin
			nv_node_ff   <= i_nv_node_id;
			o_nv_store   <= 1'b0;
		end
		else
		begin
			o_nv_store <= i_commit;
			if (i_commit)
			begin
				// Source field is never stored
				nv_node_ff   <= node_ff;                                 // [RULE_11]
				o_nv_node_id <= node_ff;
				o_nv_cfg2    <= {cfg2_ff[7], 2'b00, cfg2_ff[4:0]};
			end
		end
	end

	always @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			stag_cnt_ff  <= 16'h0000;
			stag_busy_ff <= 1'b0;
			o_conv_start <= 1'b0;
		end
		else
		begin
			stag_cnt_ff  <= nxt_stag_cnt;
			stag_busy_ff <= nxt_stag_busy;
			o_conv_start <= nxt_conv_start;
		end
	end

	// Unmapped offsets read as zero
	always @*
	begin
		o_rd_data = 8'h00;
		if (sacr_hit(i_rd_addr, `SACR_OFS_CFG2))
		begin
			o_rd_data = cfg2_ff;
		end
		else if (sacr_hit(i_rd_addr, `SACR_OFS_NODE_ID))
		begin
			o_rd_data = node_ff;
		end
		o_cfg2    = cfg2_ff;
		o_node_id = node_ff;
	end

	assign o_lock_active = locked;                                       // [RULE_09]
	// Arbitration is masked to off outside the discovery command
	assign o_arbitration_select    = i_discovery_active ? cfg2_ff[`SACR_ARB_HI:`SACR_ARB_LO] : `SACR_ARB_OFF; // [RULE_06]
	assign o_hyst_deg_c  = sacr_hyst_deg(cfg2_ff[`SACR_HYST_HI:`SACR_HYST_LO]); // [RULE_07]
	assign o_overdrive   = cfg2_ff[`SACR_BIT_OVERDRIVE];
	// Busy lets the host see that a delayed start is still owed
	assign o_conv_busy   = stag_busy_ff;

endmodule
`default_nettype wire

// ### verif/sacr_regs_props.sv
/* Checker on the register block ports.
 Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module sacr_regs_props
(
	input wire logic       i_clk,
	input wire logic       i_reset_n,
	input wire logic       i_por_load,
	input wire logic       i_wr_en,
	input wire logic [7:0] i_wr_addr,
	input wire logic       i_std_reset_pulse,
	input wire logic       i_commit,
	input wire logic [3:0] i_strap_lines,
	input wire logic       i_discovery_active,
	input wire logic [7:0] o_cfg2,
	input wire logic [7:0] o_node_id,
	input wire logic       o_nv_store,
	input wire logic [7:0] o_nv_node_id,
	input wire logic       o_lock_active,
	input wire logic [1:0] o_arbitration_select,
	input wire logic [4:0] o_hyst_deg_c,
	input wire logic       o_overdrive
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	a_od_sticky: assert property (o_overdrive && !i_std_reset_pulse && !i_por_load |=> o_overdrive)
		else $error("overdrive dropped without reset pulse");
	a_od_clear: assert property (i_std_reset_pulse && !i_por_load |=> !o_overdrive)
		else $error("overdrive kept after reset pulse");
	a_lock_sticky: assert property (o_lock_active && !i_por_load |=> o_lock_active)
		else $error("lock cleared");
	a_lock_blocks: assert property (o_lock_active && i_wr_en && !i_por_load |=> $stable(o_cfg2[6:1]))
		else $error("locked config changed");
	a_node_guard: assert property (i_wr_en && i_wr_addr == 8'h06 && o_cfg2[6:5] != 2'h0 && $stable(o_cfg2[6:5])
		&& !i_por_load |=> $stable(o_node_id))
		else $error("node write taken with decode source");
	a_hyst_map: assert property (o_hyst_deg_c == 5'd5 * ({3'h0, o_cfg2[2:1]} + 5'd1))
		else $error("hysteresis mismatch");
	a_arb_gate: assert property (o_arbitration_select == (i_discovery_active ? o_cfg2[4:3] : 2'h0))
		else $error("arbitration outside discovery");
	a_commit_store: assert property (i_commit && !i_por_load |=> o_nv_store && o_nv_node_id == $past(o_node_id))
		else $error("commit not stored");
	a_src_io: assert property ($changed(o_cfg2[6:5]) && o_cfg2[6:5] == 2'h1 && !i_por_load
		|=> o_node_id[3:0] == $past(i_strap_lines))
		else $error("strap overlay missing");
endmodule
bind sacr_regs sacr_regs_props u_props (.*);
`default_nettype wire

// ### verif/sacr_host_model.sv
/* Bus host model: scratchpad byte write closed by frame end.
 Assumes callers run between clock edges. */
`timescale 1ns/10ps
`default_nettype none
module sacr_host_model #(parameter IDLE_CYC = 4)
(
	input  wire logic       i_clk,
	output logic            o_wr_en,
	output logic [7:0]      o_wr_addr,
	output logic [7:0]      o_wr_data,
	output logic            o_frame_done
);
	initial
	begin
		o_wr_en = 0;
		o_wr_addr = 0;
		o_wr_data = 0;
		o_frame_done = 0;
	end
	task send(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_wr_en = 1;
		o_wr_addr = a;
		o_wr_data = d;
		@(negedge i_clk);
		o_wr_en = 0;
		o_wr_addr = ~a;
		o_wr_data = ~d;
		o_frame_done = 1;
		@(negedge i_clk);
		o_frame_done = 0;
		repeat (IDLE_CYC) @(negedge i_clk);
	endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
/* Bench for the register block: host writes, decode, lock, stagger.
 Assumes the host model and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk = 0, rst_n = 0, por = 0, std_rst = 0, commit = 0, disc = 0, stack = 0, req = 0;
	logic [7:0] rd_addr = 0, rd_data, cfg2, node, nv_node, nv_cfg2, wa, wd;
	logic [3:0] straps = 4'ha;
	logic [4:0] hyst;
	logic [1:0] arb;
	logic we, fd, od, lock, store, start, busy;
	logic [7:0] exp_src [4] = '{8'hc2, 8'hca, 8'hc6, 8'he6};
	int n_errors = 0, num_checks = 0, cyc = 0, k;
	always #5 clk = ~clk;
	sacr_host_model host (.i_clk(clk), .o_wr_en(we), .o_wr_addr(wa), .o_wr_data(wd), .o_frame_done(fd));
	sacr_regs dut (.i_clk(clk), .i_reset_n(rst_n), .i_por_load(por), .i_nv_cfg2(8'he6), .i_nv_node_id(8'h3c),
		.i_wr_en(we), .i_wr_addr(wa), .i_wr_data(wd), .i_frame_done(fd), .i_std_reset_pulse(std_rst),
		.i_commit(commit), .i_strap_lines(straps), .i_resistor_code(4'h6), .i_discovery_active(disc),
		.i_stacked_mode(stack), .i_conv_request(req), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_cfg2(cfg2),
		.o_node_id(node), .o_nv_store(store), .o_nv_cfg2(nv_cfg2), .o_nv_node_id(nv_node), .o_lock_active(lock),
		.o_arbitration_select(arb), .o_hyst_deg_c(hyst), .o_overdrive(od), .o_conv_start(start), .o_conv_busy(busy));
	task give_verdict;
		if (n_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk) rd_addr = a;
		#1 chk("read", rd_data, e);
	endtask
	task automatic conv(input int n);
		int t = 0;
		@(negedge clk) req = 1;
		@(negedge clk) req = 0;
		chk("busy", busy, n != 0);
		while (start !== 1'b1 && t < 500)
		begin
			@(posedge clk) #1 t++;
		end
		chk("stagger", t, n);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			n_errors++;
			give_verdict;
		end
	end
	initial
	begin
		repeat (6) @(posedge clk);
		@(negedge clk) rst_n = 1;
		@(negedge clk) por = 1;
		@(negedge clk) por = 0;
		chk("por cfg2", cfg2, 8'h86);
		chk("por node", node, 8'h3c);
		// Second reset mid-run must restore defaults over restored values
		rst_n = 0;
		repeat (6) @(negedge clk);
		rst_n = 1;
		rd(8'h05, 8'h80);
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h00);
		@(negedge clk) disc = 1;
		for (k = 0; k < 4; k++)
		begin
			host.send(8'h05, {3'h4, k[1:0], k[1:0], 1'b0});
			chk("arb", arb, k);
			chk("hyst", hyst, 5 * (k + 1));
		end
		disc = 0;
		#1 chk("arb idle", arb, 0);
		host.send(8'h05, 8'h00);
		chk("od", od, 1);
		@(negedge clk) std_rst = 1;
		@(negedge clk) std_rst = 0;
		chk("od", od, 0);
		host.send(8'h05, 8'h80);
		chk("od", od, 1);
		host.send(8'h06, 8'hc2);
		rd(8'h06, 8'hc2);
		@(negedge clk) commit = 1;
		@(negedge clk) commit = 0;
		chk("store", store, 1);
		chk("nv node", nv_node, 8'hc2);
		chk("nv cfg2", nv_cfg2, 8'h80);
		host.send(8'h06, 8'h01);
		conv(0);
		@(negedge clk) stack = 1;
		conv(100);
		for (k = 1; k < 4; k++)
		begin
			host.send(8'h05, {1'b1, k[1:0], 5'h00});
			chk("node src", node, exp_src[k]);
		end
		@(negedge clk) straps = 4'h5;
		host.send(8'h05, 8'he0);
		chk("same src", node, 8'he6);
		host.send(8'h06, 8'h11);
		chk("node wr", node, 8'he6);
		host.send(8'h05, 8'h61);
		chk("lock", lock, 1);
		host.send(8'h05, 8'h02);
		chk("locked cfg2", cfg2, 8'he1);
		give_verdict;
	end
endmodule
`default_nettype wire
